// *** verilog/pkled_top.sv ***
// Purpose: Key timing, status LED, pairing window and peer filter
// Assumes: Key level is debounced and synchronous; radio gives parsed frames
// Notes:   All timing counts run on the 1 ms tick of pkled_tick
//
// How it works
// - After power-on the LED is solid for 5 s, then the block goes idle with a slow flash.
// - A key held over 10 s makes the LED flash fast and starts pairing on release.
// - Pairing lasts at most 30 s and falls back to idle when no peer pairs.
// - A successful pairing ends the window at once and makes the LED solid.
// - Audio is passed on only from the stored peer; every other transmitter is ignored.
// - Identities are matched and stored on their low two bytes only.
// - A download tool present on the UART at restart selects in-system programming mode.
// - A key press over 3 s but not over 10 s turns the module off; when off, any press over 3 s turns it on.
// - With standby selected, the standby output goes low after over 5 min without signal.
`timescale 1ns/100ps
`include "pkled_regs.svh"

module pkled_top
  import pkled_pkg::*;
#(
  parameter int TICK_CYC     = `PKLED_TICK_CYC,
  parameter int POWERON_T    = `PKLED_POWERON_T,
  parameter int POWER_HOLD_T = `PKLED_POWER_HOLD_T,
  parameter int PAIR_HOLD_T  = `PKLED_PAIR_HOLD_T,
  parameter int PAIR_WIN_T   = `PKLED_PAIR_WIN_T,
  parameter int STANDBY_T    = `PKLED_STANDBY_T,
  parameter int SLOW_HALF_T  = `PKLED_SLOW_HALF_T,
  parameter int FAST_HALF_T  = `PKLED_FAST_HALF_T
) (
  // System
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  // Key and restart strap
  input  wire logic                       key_in,
  input  wire logic                       uart_tool_in,
  // Pairing link
  input  wire logic                       pair_req_valid_in,
  input  wire logic [31:0]                pair_req_id_in,
  input  wire logic [31:0]                native_id_in,
  // Audio from radio
  input  wire logic                       rx_valid_in,
  input  wire pkled_frame_t               rx_frame_in,
  // Standby select
  input  wire logic                       standby_sel_in,
  // Status outputs
  output logic                            led_q,
  output pkled_stat_t                     stat_q,
  output logic [`PKLED_ID_LOW_W-1:0]      beacon_id_q,
  output logic                            pair_done_q,
  output logic                            standby_n_q,
  // Audio out
  output logic                            audio_valid_q,
  output logic [23:0]                     audio_sample_q
);

  localparam int TW = `PKLED_TIMER_W;
  localparam logic [TW-1:0] P_ON   = TW'(POWERON_T);
  localparam logic [TW-1:0] P_PWR  = TW'(POWER_HOLD_T);
  localparam logic [TW-1:0] P_PAIR = TW'(PAIR_HOLD_T);
  localparam logic [TW-1:0] P_WIN  = TW'(PAIR_WIN_T);
  localparam logic [TW-1:0] P_SBY  = TW'(STANDBY_T);

  if (POWERON_T < 1 || PAIR_WIN_T < 1 || POWER_HOLD_T >= PAIR_HOLD_T ||
      STANDBY_T + 1 >= 2 ** TW) begin : g_chk
    $error("pkled_top: timing parameters out of range");
  end

  // ==========================================================
  // Helpers
  function automatic logic [`PKLED_ID_LOW_W-1:0] id_low(input logic [31:0] id);
    return id[`PKLED_ID_LOW_W-1:0];
  endfunction

  function automatic logic [TW-1:0] bump(input logic [TW-1:0] v);
    return v + 1'b1;
  endfunction

  // ==========================================================
  // Time base
  logic tick, slow_ph, fast_ph;

  pkled_tick #(
    .TICK_CYC    (TICK_CYC),
    .SLOW_HALF_T (SLOW_HALF_T),
    .FAST_HALF_T (FAST_HALF_T)
  ) u_tick (
    .clock     (clock),
    .rst_b     (rst_b),
    .tick_q    (tick),
    .slow_ph_q (slow_ph),
    .fast_ph_q (fast_ph)
  );

  // ==========================================================
  // Mode sequencer
  pkled_state_t                state_q, state_d;
  logic [TW-1:0]               timer_q, timer_d, hold_q, hold_d, idle_q, idle_d;
  logic                        key_q, have_pair_q, have_pair_d;
  logic [`PKLED_ID_LOW_W-1:0]  paired_id_q, paired_id_d, beacon_id_d;
  logic                        led_d, pair_done_d, standby_n_d, accept;
  logic                        rel, long_hold, mid_hold;
  pkled_stat_t                 stat_d;

  assign rel       = key_q & ~key_in;
  assign long_hold = hold_q > P_PAIR;
  assign mid_hold  = hold_q > P_PWR;

  always_comb begin
    state_d     = state_q;
    timer_d     = timer_q;
    hold_d      = '0;
    paired_id_d = paired_id_q;
    have_pair_d = have_pair_q;
    pair_done_d = 1'b0;
    if (key_in) begin
      hold_d = (tick && !long_hold) ? bump(hold_q) : hold_q;
    end
    case (state_q)
      ST_BOOT: begin
        state_d = uart_tool_in ? ST_ISP : ST_POWERUP;
        timer_d = '0;
      end
      ST_POWERUP: begin
        if (tick) begin
          timer_d = bump(timer_q);
          if (timer_q >= P_ON - 1'b1) begin
            state_d = ST_IDLE;
            timer_d = '0;
          end
        end
      end
      ST_IDLE, ST_PAIRED: begin
        if (rel && long_hold) begin
          state_d = ST_PAIRING;
          timer_d = '0;
        end else if (rel && mid_hold) begin
          state_d = ST_OFF;
        end
      end
      ST_PAIRING: begin
        if (pair_req_valid_in) begin
          state_d     = ST_PAIRED;
          have_pair_d = 1'b1;
          pair_done_d = 1'b1;
          paired_id_d = id_low(pair_req_id_in);
        end else if (tick) begin
          timer_d = bump(timer_q);
          if (timer_q >= P_WIN - 1'b1) begin
            state_d = ST_IDLE;
            timer_d = '0;
          end
        end
      end
      ST_OFF: begin
        if (rel && mid_hold) begin
          state_d = ST_POWERUP;
          timer_d = '0;
        end
      end
      ST_ISP: begin
        state_d = ST_ISP;
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
  end

  // ==========================================================
  // LED, peer filter, standby
  always_comb begin
    case (state_q)
      ST_POWERUP: led_d = 1'b1;
      // fast flash once held long enough
      ST_IDLE:    led_d = long_hold ? fast_ph : slow_ph;
      ST_PAIRED:  led_d = long_hold ? fast_ph : 1'b1;
      ST_PAIRING: led_d = fast_ph;
      default:    led_d = 1'b0;
    endcase
    // only the stored peer gets through
    accept = rx_valid_in && have_pair_q && (state_q == ST_IDLE || state_q == ST_PAIRED) &&
             (id_low(rx_frame_in.id) == paired_id_q);
    idle_d = idle_q;
    if (accept) begin
      idle_d = '0;
    end else if (tick && idle_q <= P_SBY) begin
      idle_d = bump(idle_q);
    end
    standby_n_d = !(standby_sel_in && idle_q > P_SBY);
    beacon_id_d = (state_d == ST_PAIRING) ? id_low(native_id_in) : '0;
    stat_d.power_on = (state_d != ST_OFF) && (state_d != ST_BOOT) && (state_d != ST_ISP);
    stat_d.pairing  = state_d == ST_PAIRING;
    stat_d.paired   = have_pair_d;
    stat_d.in_system_programming_mode = state_d == ST_ISP;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q        <= ST_BOOT;
      timer_q        <= '0;
      hold_q         <= '0;
      idle_q         <= '0;
      key_q          <= 1'b0;
      have_pair_q    <= 1'b0;
      paired_id_q    <= '0;
      led_q          <= 1'b0;
      stat_q         <= '0;
      beacon_id_q    <= '0;
      pair_done_q    <= 1'b0;
      standby_n_q    <= 1'b1;
      audio_valid_q  <= 1'b0;
      audio_sample_q <= '0;
    end else begin
      state_q        <= state_d;
      timer_q        <= timer_d;
      hold_q         <= hold_d;
      idle_q         <= idle_d;
      key_q          <= key_in;
      have_pair_q    <= have_pair_d;
      paired_id_q    <= paired_id_d;
      led_q          <= led_d;
      stat_q         <= stat_d;
      beacon_id_q    <= beacon_id_d;
      pair_done_q    <= pair_done_d;
      standby_n_q    <= standby_n_d;
      audio_valid_q  <= accept;
      audio_sample_q <= accept ? rx_frame_in.sample : audio_sample_q;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  powerup_solid_a: assert property (
    state_q == ST_POWERUP |=> led_q) else $error("LED not solid at power-up");
  powerup_exit_a: assert property (
    state_q == ST_POWERUP && tick && timer_q == P_ON - 1'b1 |=> state_q == ST_IDLE)
    else $error("Power-up did not end after its time");
  idle_slow_a: assert property (
    state_q == ST_IDLE && !long_hold |=> led_q == $past(slow_ph))
    else $error("Idle LED not slow flash");
  hold_fast_a: assert property (
    state_q == ST_IDLE && long_hold |=> led_q == $past(fast_ph))
    else $error("Long hold LED not fast flash");
  pair_enter_a: assert property (
    state_q == ST_IDLE && rel && long_hold |=> state_q == ST_PAIRING && timer_q == '0)
    else $error("Pairing not entered on release");
  pair_timeout_a: assert property (
    state_q == ST_PAIRING && !pair_req_valid_in && tick && timer_q == P_WIN - 1'b1
    |=> state_q == ST_IDLE) else $error("Pairing window did not time out");
  pair_done_a: assert property (
    state_q == ST_PAIRING && pair_req_valid_in
    |=> state_q == ST_PAIRED && pair_done_q ##1 led_q) else $error("Pairing success mishandled");
  foreign_drop_a: assert property (
    rx_valid_in && id_low(rx_frame_in.id) != paired_id_q |=> !audio_valid_q)
    else $error("Foreign transmitter audio passed");
  pair_id_a: assert property (
    state_q == ST_PAIRING && pair_req_valid_in
    |=> paired_id_q == $past(pair_req_id_in[15:0])) else $error("Paired identity wrong");
  isp_entry_a: assert property (
    state_q == ST_BOOT && uart_tool_in |=> (state_q == ST_ISP)[*3])
    else $error("Programming mode not held");
  power_off_a: assert property (
    (state_q == ST_IDLE || state_q == ST_PAIRED) && rel && mid_hold && !long_hold
    |=> state_q == ST_OFF ##1 !led_q)
    else $error("Medium press did not power off");
  standby_a: assert property (
    standby_sel_in && idle_q > P_SBY && !accept |=> !standby_n_q && idle_q > P_SBY)
    else $error("Standby not asserted after silence");

  pair_ok_c:  cover property (state_q == ST_PAIRING ##1 pair_done_q);
  pair_to_c:  cover property (state_q == ST_PAIRING ##1 state_q == ST_IDLE);
  isp_c:      cover property (state_q == ST_ISP);
  standby_c:  cover property ($fell(standby_n_q));

endmodule

// *** pkg/pkled_regs.svh ***
// Purpose: Timing constants for the pairing key and LED supervisor
// Assumes: 100 MHz system clock, 1 ms time base
// Notes:   Times keep their printed unit; tick counts derive from them
`ifndef PKLED_REGS_SVH
`define PKLED_REGS_SVH

// ==========================================================
// Clock and time base
`define PKLED_CLK_HZ        100000000
`define PKLED_TICK_MS       1
`define PKLED_TICK_CYC      ((`PKLED_CLK_HZ / 1000) * `PKLED_TICK_MS)

// ==========================================================
// Printed times
`define PKLED_POWERON_S     5
`define PKLED_PAIR_HOLD_S   10
`define PKLED_PAIR_WIN_S    30
`define PKLED_POWER_HOLD_S  3
`define PKLED_STANDBY_MIN   5
`define PKLED_SLOW_HZ       1
`define PKLED_FAST_HZ       4

// ==========================================================
// Counts in time base ticks
`define PKLED_POWERON_T     (`PKLED_POWERON_S * 1000 / `PKLED_TICK_MS)
`define PKLED_PAIR_HOLD_T   (`PKLED_PAIR_HOLD_S * 1000 / `PKLED_TICK_MS)
`define PKLED_PAIR_WIN_T    (`PKLED_PAIR_WIN_S * 1000 / `PKLED_TICK_MS)
`define PKLED_POWER_HOLD_T  (`PKLED_POWER_HOLD_S * 1000 / `PKLED_TICK_MS)
`define PKLED_STANDBY_T     (`PKLED_STANDBY_MIN * 60000 / `PKLED_TICK_MS)
`define PKLED_SLOW_HALF_T   (1000 / (2 * `PKLED_SLOW_HZ * `PKLED_TICK_MS))
`define PKLED_FAST_HALF_T   (1000 / (2 * `PKLED_FAST_HZ * `PKLED_TICK_MS))

// ==========================================================
// Widths
`define PKLED_ID_LOW_W      16
`define PKLED_TIMER_W       20

`endif

// *** pkg/pkled_pkg.sv ***
// Purpose: Types shared by the pairing key and LED supervisor
// Assumes: Nothing beyond the header of constants
// Notes:   Frame carries a full identity; only its low half is matched
package pkled_pkg;

  // ==========================================================
  // Supervisor modes
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_POWERUP,
    ST_IDLE,
    ST_PAIRING,
    ST_PAIRED,
    ST_OFF,
    ST_ISP
  } pkled_state_t;

  // ==========================================================
  // Radio frame and status
  typedef struct packed {
    logic [31:0] id;
    logic [23:0] sample;
  } pkled_frame_t;

  typedef struct packed {
    logic power_on;
    logic pairing;
    logic paired;
    logic in_system_programming_mode;
  } pkled_stat_t;

endpackage

// *** verilog/pkled_tick.sv ***
// Purpose: Millisecond time base and LED flash phases
// Assumes: Free running system clock
// Notes:   Phases toggle every half period counted in ticks
`timescale 1ns/100ps
`include "pkled_regs.svh"

module pkled_tick
  import pkled_pkg::*;
#(
  parameter int TICK_CYC    = `PKLED_TICK_CYC,
  parameter int SLOW_HALF_T = `PKLED_SLOW_HALF_T,
  parameter int FAST_HALF_T = `PKLED_FAST_HALF_T
) (
  // System
  input  wire logic clock,
  input  wire logic rst_b,
  // Time base
  output logic      tick_q,
  output logic      slow_ph_q,
  output logic      fast_ph_q
);

  localparam int DW = $clog2(TICK_CYC + 1);
  localparam int PW = $clog2(SLOW_HALF_T + 1);
  localparam logic [DW-1:0] DIV_LAST  = DW'(TICK_CYC - 1);
  localparam logic [PW-1:0] SLOW_LAST = PW'(SLOW_HALF_T - 1);
  localparam logic [PW-1:0] FAST_LAST = PW'(FAST_HALF_T - 1);

  if (TICK_CYC < 2 || FAST_HALF_T < 1 || SLOW_HALF_T <= FAST_HALF_T) begin : g_chk
    $error("pkled_tick: unusable time base or flash parameters");
  end

  logic [DW-1:0] div_q, div_d;
  logic [PW-1:0] slow_q, slow_d, fast_q, fast_d;
  logic          tick_d, slow_ph_d, fast_ph_d;

  // ==========================================================
  // Divider and flash phases
  // distinct flash rates
  always_comb begin
    div_d     = div_q + 1'b1;
    tick_d    = 1'b0;
    slow_d    = slow_q;
    fast_d    = fast_q;
    slow_ph_d = slow_ph_q;
    fast_ph_d = fast_ph_q;
    if (div_q == DIV_LAST) begin
      div_d  = '0;
      tick_d = 1'b1;
      slow_d = (slow_q == SLOW_LAST) ? '0 : slow_q + 1'b1;
      fast_d = (fast_q == FAST_LAST) ? '0 : fast_q + 1'b1;
      if (slow_q == SLOW_LAST) begin
        slow_ph_d = ~slow_ph_q;
      end
      if (fast_q == FAST_LAST) begin
        fast_ph_d = ~fast_ph_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      div_q     <= '0;
      slow_q    <= '0;
      fast_q    <= '0;
      tick_q    <= 1'b0;
      slow_ph_q <= 1'b1;
      fast_ph_q <= 1'b1;
    end else begin
      div_q     <= div_d;
      slow_q    <= slow_d;
      fast_q    <= fast_d;
      tick_q    <= tick_d;
      slow_ph_q <= slow_ph_d;
      fast_ph_q <= fast_ph_d;
    end
  end

endmodule

// *** tb/pkled_peer_model.sv ***
// Purpose: Transmitter peer and user key that stimulate the supervisor
// Assumes: Stimulus changes at the falling clock edge
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/100ps

module pkled_peer_model
  import pkled_pkg::*;
(
  // System
  input  wire logic   clock,
  // Key and pairing
  output logic         key_in,
  output logic         pair_req_valid_in,
  output logic [31:0]  pair_req_id_in,
  // Audio frames
  output logic         rx_valid_in,
  output pkled_frame_t rx_frame_in
);

  initial begin
    key_in = 1'b0;
    pair_req_valid_in = 1'b0;
    pair_req_id_in = 32'h0000_0000;
    rx_valid_in = 1'b0;
    rx_frame_in = '0;
  end

  // ==========================================================
  // Key
  // key hold time
  task automatic press(input int cyc);
    @(negedge clock);
    key_in = 1'b1;
    repeat (cyc) @(negedge clock);
    key_in = 1'b0;
  endtask

  // ==========================================================
  // Radio side
  // one-cycle pairing offer
  task automatic offer(input logic [31:0] id);
    @(negedge clock);
    pair_req_valid_in = 1'b1;
    pair_req_id_in = id;
    @(negedge clock);
    pair_req_valid_in = 1'b0;
    pair_req_id_in = ~id;
  endtask

  // Back to back frames leave valid high until the last one
  task automatic send(input logic [31:0] id, input logic [23:0] s, input bit last);
    @(negedge clock);
    rx_valid_in = 1'b1;
    rx_frame_in = {id, s};
    if (last) begin
      @(negedge clock);
      rx_valid_in = 1'b0;
      rx_frame_in = ~rx_frame_in;
    end
  endtask

endmodule

// *** tb/pkled_top_tb_top.sv ***
// Purpose: Self-checking bench for the pairing key and LED supervisor
// Assumes: Shortened timing parameters, 4 clocks per tick
// Notes:   Audio samples are predicted in a queue and popped per output
`timescale 1ns/100ps

module pkled_top_tb_top import pkled_pkg::*; ();

  logic               clock;
  logic               rst_b;
  logic               uart_tool_in;
  logic               standby_sel_in;
  logic               key_in;
  logic               pair_req_valid_in;
  logic [31:0]        pair_req_id_in;
  logic [31:0]        native_id_in;
  logic               rx_valid_in;
  pkled_frame_t       rx_frame_in;
  logic               led_q;
  pkled_stat_t        stat_q;
  logic [15:0]        beacon_id_q;
  logic               pair_done_q;
  logic               standby_n_q;
  logic               audio_valid_q;
  logic [23:0]        audio_sample_q;
  int                 err_total;
  int                 checks_done;
  logic [23:0]        exp_q[$];
  logic [31:0]        pid;
  logic [31:0]        hi;
  bit                 ok;
  bit                 tool_rand;
  bit                 tool_lvl;
  bit                 sby_rand;
  bit                 sby_lvl;

  // Shortened timing, in clocks per tick and in ticks
  localparam int TB_TICK = 4, TB_ON = 5, TB_PWR = 3, TB_PAIR = 10;
  localparam int TB_WIN = 30, TB_SBY = 50, TB_SLOW = 4, TB_FAST = 1;

  always #5 clock = ~clock;

  // Strap and standby select: random while free, pinned level otherwise
  always @(negedge clock) begin
    uart_tool_in   = tool_rand ? 1'($urandom()) : tool_lvl;
    standby_sel_in = sby_rand ? 1'($urandom()) : sby_lvl;
  end

  pkled_top #(.TICK_CYC(TB_TICK), .POWERON_T(TB_ON), .POWER_HOLD_T(TB_PWR),
    .PAIR_HOLD_T(TB_PAIR), .PAIR_WIN_T(TB_WIN), .STANDBY_T(TB_SBY), .SLOW_HALF_T(TB_SLOW),
    .FAST_HALF_T(TB_FAST)) dut (
    .clock(clock), .rst_b(rst_b), .key_in(key_in), .uart_tool_in(uart_tool_in),
    .pair_req_valid_in(pair_req_valid_in), .pair_req_id_in(pair_req_id_in),
    .native_id_in(native_id_in), .rx_valid_in(rx_valid_in), .rx_frame_in(rx_frame_in),
    .standby_sel_in(standby_sel_in), .led_q(led_q), .stat_q(stat_q),
    .beacon_id_q(beacon_id_q), .pair_done_q(pair_done_q), .standby_n_q(standby_n_q),
    .audio_valid_q(audio_valid_q), .audio_sample_q(audio_sample_q));

  pkled_peer_model u_peer (
    .clock(clock), .key_in(key_in), .pair_req_valid_in(pair_req_valid_in),
    .pair_req_id_in(pair_req_id_in), .rx_valid_in(rx_valid_in), .rx_frame_in(rx_frame_in));

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Counts LED edges over n cycles, one edge of slack for tick phase
  task automatic flash(input int n, input int exp);
    int   c;
    logic p;
    c = 0;
    p = led_q;
    repeat (n) begin
      @(negedge clock);
      if (led_q !== p) c++;
      p = led_q;
    end
    chk("led edge count in range", 1, (c >= exp - 1) && (c <= exp + 1));
  endtask

  task automatic tx(input logic [31:0] id, input logic [23:0] s, input bit last,
                    input bit acc);
    if (acc) exp_q.push_back(s);
    u_peer.send(id, s, last);
  endtask

  // ==========================================================
  // Audio output monitor
  always @(negedge clock) begin
    if (audio_valid_q === 1'b1) begin
      if (exp_q.size() == 0) chk("audio unexpected frame", 0, 1);
      else chk("audio sample", exp_q.pop_front(), audio_sample_q);
    end
  end

  initial begin
    #(20000 * 10);
    err_total++;
    end_of_test();
  end

  // ==========================================================
  // Scenarios
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    tool_rand = 1'b0;
    tool_lvl = 1'b0;
    sby_rand = 1'b0;
    sby_lvl = 1'b0;
    err_total = 0;
    checks_done = 0;
    void'($urandom(50633));
    native_id_in = $urandom();
    cyc(3);
    chk("standby in reset", 1, standby_n_q);
    chk("led in reset", 0, led_q);
    rst_b = 1'b1;
    cyc(10);
    chk("led power up", 1, led_q);
    chk("power on", 1, stat_q.power_on);
    tool_rand = 1'b1;
    sby_rand = 1'b1;
    cyc(25);
    flash(128, 8);
    fork
      u_peer.press(80);
      begin
        cyc(52);
        flash(28, 7);
      end
    join
    cyc(3);
    chk("pairing entered", 1, stat_q.pairing);
    chk("beacon id", {16'h0000, native_id_in[15:0]}, beacon_id_q);
    cyc(105);
    chk("pairing still open", 1, stat_q.pairing);
    cyc(20);
    chk("pairing timed out", 0, stat_q.pairing);
    chk("beacon cleared", 0, beacon_id_q);
    pid = $urandom();
    u_peer.offer(pid);
    cyc(2);
    chk("offer outside window", 0, stat_q.paired);
    tx(pid, 24'($urandom()), 1'b1, 1'b0);
    u_peer.press(60);
    cyc(3);
    chk("pairing again", 1, stat_q.pairing);
    u_peer.offer(pid);
    chk("pair done", 1, pair_done_q);
    chk("pairing left", 0, stat_q.pairing);
    chk("paired", 1, stat_q.paired);
    cyc(1);
    chk("led solid", 1, led_q);
    chk("pair done pulse", 0, pair_done_q);
    for (int i = 0; i < 6; i++) begin
      hi = $urandom();
      ok = (i % 3) != 2;
      tx(ok ? {hi[15:0], pid[15:0]} : {pid[15:0], ~pid[15:0]}, 24'($urandom()), i == 5, ok);
    end
    sby_rand = 1'b0;
    cyc(3);
    chk("audio pending", 0, exp_q.size());
    chk("standby not selected", 1, standby_n_q);
    sby_lvl = 1'b1;
    cyc(180);
    chk("standby before limit", 1, standby_n_q);
    cyc(40);
    chk("standby asserted", 0, standby_n_q);
    tx(pid, 24'($urandom()), 1'b1, 1'b1);
    cyc(3);
    chk("standby after frame", 1, standby_n_q);
    cyc(230);
    sby_lvl = 1'b0;
    cyc(2);
    chk("standby deselected", 1, standby_n_q);
    sby_rand = 1'b1;
    u_peer.press(8);
    cyc(3);
    chk("short press ignored", 1, stat_q.power_on);
    u_peer.press(24);
    cyc(3);
    chk("power off", 0, stat_q.power_on);
    chk("led off", 0, led_q);
    tx(pid, 24'($urandom()), 1'b1, 1'b0);
    u_peer.press(24);
    cyc(3);
    chk("power on again", 1, stat_q.power_on);
    chk("led solid again", 1, led_q);
    cyc(30);
    tx(pid, 24'($urandom()), 1'b1, 1'b1);
    cyc(3);
    chk("audio drained", 0, exp_q.size());
    rst_b = 1'b0;
    tool_rand = 1'b0;
    tool_lvl = 1'b1;
    cyc(3);
    rst_b = 1'b1;
    cyc(4);
    tool_rand = 1'b1;
    chk("programming mode", 1, stat_q.in_system_programming_mode);
    chk("programming power", 0, stat_q.power_on);
    u_peer.press(60);
    cyc(3);
    chk("key in programming", 0, stat_q.pairing);
    chk("led in programming", 0, led_q);
    end_of_test();
  end

endmodule
